// File: hw/fdc_param_map.svh
// Operation
// - Direction 0 steps out, 1 steps in
// - Per-drive bit 1 marks perpendicular drive
// - Size code zero: special length sets transfer
// - Reads keep excess sector bytes from host
// - Writes pad excess sector with zero bytes
// - Check code covers the whole physical sector
// - Nonzero size code ignores special length
// - Implied seek before cylinder read/write commands
// - Sequencing stops at last sector number
// - Perpendicular gap select changes second gap
// - Gap three length sets inter-sector spacing
// - Head address selects side 0 or 1
// - Wait head load time before transfer
// - Unload head after unload interval elapses
// - Lock keeps config over software reset
// - Density one is MFM, zero is FM
// - Multi-track spans head 0 then head 1
// - Multi-track continues to head 1 automatically
`ifndef FDC_PARAM_MAP_SVH
`define FDC_PARAM_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_GEOM 8'h04
`define OFS_GAP 8'h08
`define OFS_TIME 8'h0c
`define OFS_CONFIG 8'h10
`define OFS_CYL 8'h14
`define OFS_STATUS 8'h18
`define OFS_CRC 8'h1c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_START 0
`define CTRL_OP_LSB 1
`define CTRL_DIR 3
`define CTRL_DS_LSB 4
`define CTRL_HEAD 6
`define CTRL_MFM 7
`define CTRL_MT 8
`define CTRL_EIS 9
`define CTRL_LOCK 10
`define CTRL_SRST 11

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define DTL_RESET 8'hff
`define EOT_RESET 8'h12
`define FIRST_SECTOR 8'h01
`define GPL_RESET 8'h1b
`define FIFO_EN_N_RESET 1'b1
`define FIFO_THR_RESET 4'h0
`define PRECOMP_START_TRACK_RESET 8'h00
`define BASE_SECTOR 15'h0080
`define TIME_UNIT_US 1000
`define CLK_MHZ 25
`define STEP_UNITS 8'h03

`endif

// File: hw/fdc_param_pkg.sv
package fdc_param_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_LOAD = 3'b010,
    ST_XFER = 3'b011,
    ST_NEXT = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_RSEEK = 2'b10,
    OP_NONE = 2'b11
  } op_t;

  typedef struct packed {
    logic [3:0] drive_enable;
    logic [1:0] drive_sel;
    logic perpendicular;
    logic head_sel;
    logic head_loaded;
    logic mfm_mode;
    logic step_in;
    logic step;
    logic [7:0] gap_two_len;
    logic [7:0] gap_three_length;
  } drive_ctrl_t;

endpackage : fdc_param_pkg

// File: hw/floppy_command_parameters.sv
`timescale 1ns/1ps
`include "fdc_param_map.svh"

module floppy_command_parameters
  import fdc_param_pkg::*;
#(
  parameter int TICK_CYCLES = `TIME_UNIT_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic disk_byte_tick,
  input wire logic [7:0] disk_rd_byte,
  input wire logic disk_rd_valid,
  output logic [7:0] disk_wr_byte,
  output logic disk_wr_valid,
  input wire logic [7:0] host_wr_byte,
  input wire logic host_wr_valid,
  output logic host_wr_ready,
  output logic [7:0] host_rd_byte,
  output logic host_rd_valid,
  output drive_ctrl_t drive_ctrl,
  output logic fifo_enable_n,
  output logic [3:0] fifo_threshold,
  output logic [7:0] precomp_start_track,
  output logic busy
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction : crc_step

  function automatic logic [3:0] drive_decode(input logic [1:0] sel);
    return 4'h1 << sel;
  endfunction : drive_decode

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [11:1] ctrl_reg;
  logic [2:0] size_code_reg;
  logic [7:0] special_sector_length_reg;
  logic [7:0] last_sector_number_reg;
  logic [7:0] gap_three_length_reg;
  logic [7:0] gap_two_len_reg;
  logic gap_select_reg;
  logic [3:0] perp_drives_reg;
  logic [7:0] head_load_time_reg;
  logic [7:0] head_unload_time_reg;
  logic fifo_enable_n_reg;
  logic [3:0] fifo_threshold_reg;
  logic [7:0] precomp_start_track_reg;
  logic [7:0] cylinder_reg;
  logic [31:0] prdata_reg;

  logic wr_en;
  logic rd_setup;
  logic start;
  logic soft_reset;
  logic addr_ok;

  assign addr_ok = (paddr == `OFS_CTRL) || (paddr == `OFS_GEOM) || (paddr == `OFS_GAP) ||
                   (paddr == `OFS_TIME) || (paddr == `OFS_CONFIG) || (paddr == `OFS_CYL) ||
                   (paddr == `OFS_STATUS) || (paddr == `OFS_CRC);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign start = wr_en && (paddr == `OFS_CTRL) && pwdata[`CTRL_START];
  assign soft_reset = wr_en && (paddr == `OFS_CTRL) && pwdata[`CTRL_SRST];

  // Command parameters; a soft reset restores geometry, gap three, gap select and drive flags, not gap two, head times or cylinder
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= '0;
      size_code_reg <= 3'h0;
      special_sector_length_reg <= `DTL_RESET;
      last_sector_number_reg <= `EOT_RESET;
      gap_three_length_reg <= `GPL_RESET;
      gap_two_len_reg <= 8'h16;
      gap_select_reg <= 1'b0;
      perp_drives_reg <= 4'h0;
      head_load_time_reg <= 8'h01;
      head_unload_time_reg <= 8'h01;
      cylinder_reg <= 8'h00;
    end else if (soft_reset) begin
      ctrl_reg <= {1'b0, ctrl_reg[`CTRL_LOCK], 9'h000};
      size_code_reg <= 3'h0;
      special_sector_length_reg <= `DTL_RESET;
      last_sector_number_reg <= `EOT_RESET;
      gap_three_length_reg <= `GPL_RESET;
      gap_select_reg <= 1'b0;
      perp_drives_reg <= 4'h0;
    end else if (wr_en) begin
      unique case (paddr)
        `OFS_CTRL: ctrl_reg <= {1'b0, pwdata[10:1]};
        `OFS_GEOM: begin
          size_code_reg <= pwdata[2:0];
          special_sector_length_reg <= pwdata[15:8];
          last_sector_number_reg <= pwdata[23:16];
        end
        `OFS_GAP: begin
          gap_three_length_reg <= pwdata[7:0];
          gap_two_len_reg <= pwdata[15:8];
          gap_select_reg <= pwdata[16];
          perp_drives_reg <= pwdata[23:20];
        end
        `OFS_TIME: begin
          head_load_time_reg <= pwdata[7:0];
          head_unload_time_reg <= pwdata[15:8];
        end
        `OFS_CYL: cylinder_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Configuration survives a soft reset while locked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_enable_n_reg <= `FIFO_EN_N_RESET;
      fifo_threshold_reg <= `FIFO_THR_RESET;
      precomp_start_track_reg <= `PRECOMP_START_TRACK_RESET;
    end else if (soft_reset && !ctrl_reg[`CTRL_LOCK]) begin
      fifo_enable_n_reg <= `FIFO_EN_N_RESET;
      fifo_threshold_reg <= `FIFO_THR_RESET;
      precomp_start_track_reg <= `PRECOMP_START_TRACK_RESET;
    end else if (wr_en && paddr == `OFS_CONFIG) begin
      fifo_enable_n_reg <= pwdata[0];
      fifo_threshold_reg <= pwdata[7:4];
      precomp_start_track_reg <= pwdata[15:8];
    end
  end

  assign fifo_enable_n = fifo_enable_n_reg;
  assign fifo_threshold = fifo_threshold_reg;
  assign precomp_start_track = precomp_start_track_reg;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
  logic [14:0] tick_cnt_reg;
  logic unit_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 15'h0000;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= 15'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 15'h0001;
    end
  end
  assign unit_tick = (tick_cnt_reg == TICK_LAST);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  state_t state_reg;
  op_t op_reg;
  logic [7:0] pcn_reg;
  logic [7:0] steps_left_reg;
  logic step_in_reg;
  logic step_reg;
  logic [7:0] wait_reg;
  logic head_loaded_reg;
  logic [7:0] unload_cnt_reg;
  logic head_reg;
  logic [7:0] sector_reg;
  logic [14:0] byte_idx_reg;
  logic [15:0] crc_reg;
  logic [15:0] crc_last_reg;
  logic [14:0] phys_len;
  logic [14:0] xfer_len;
  logic byte_done;
  logic sector_end;
  logic last_on_track;
  logic host_part;

  assign phys_len = `BASE_SECTOR << size_code_reg;
  // Special length only counts with size code zero, capped to the sector
  assign xfer_len = (size_code_reg == 3'h0) ?
                    ((special_sector_length_reg > 8'h80) ? `BASE_SECTOR : {7'h00, special_sector_length_reg})
                    : phys_len;
  assign host_part = (byte_idx_reg < xfer_len);
  assign host_wr_ready = (state_reg == ST_XFER) && (op_reg == OP_WRITE) && disk_byte_tick && host_part;
  assign byte_done = (state_reg == ST_XFER) &&
                     ((op_reg == OP_READ) ? disk_rd_valid
                      : (disk_byte_tick && (!host_part || host_wr_valid)));
  assign sector_end = byte_done && (byte_idx_reg == phys_len - 15'h0001);
  assign last_on_track = (sector_reg == last_sector_number_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
      steps_left_reg <= 8'h00;
      step_in_reg <= 1'b0;
      wait_reg <= 8'h00;
      head_reg <= 1'b0;
      sector_reg <= `FIRST_SECTOR;
    end else if (soft_reset) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            op_reg <= op_t'(pwdata[`CTRL_OP_LSB +: 2]);
            head_reg <= pwdata[`CTRL_HEAD];
            sector_reg <= `FIRST_SECTOR;
            wait_reg <= `STEP_UNITS;
            if (op_t'(pwdata[`CTRL_OP_LSB +: 2]) == OP_RSEEK) begin
              steps_left_reg <= cylinder_reg;
              step_in_reg <= pwdata[`CTRL_DIR];
              state_reg <= ST_SEEK;
            end else if (op_t'(pwdata[`CTRL_OP_LSB +: 2]) == OP_NONE) begin
              state_reg <= ST_IDLE;
            end else if (pwdata[`CTRL_EIS] && cylinder_reg != pcn_reg) begin
              steps_left_reg <= (cylinder_reg > pcn_reg) ? cylinder_reg - pcn_reg : pcn_reg - cylinder_reg;
              step_in_reg <= (cylinder_reg > pcn_reg);
              state_reg <= ST_SEEK;
            end else begin
              wait_reg <= head_load_time_reg;
              state_reg <= head_loaded_reg ? ST_XFER : ST_LOAD;
            end
          end
        end
        ST_SEEK: begin
          if (steps_left_reg == 8'h00) begin
            wait_reg <= head_load_time_reg;
            state_reg <= (op_reg == OP_RSEEK) ? ST_IDLE : (head_loaded_reg ? ST_XFER : ST_LOAD);
          end else if (unit_tick) begin
            if (wait_reg <= 8'h01) begin
              wait_reg <= `STEP_UNITS;
              steps_left_reg <= steps_left_reg - 8'h01;
            end else begin
              wait_reg <= wait_reg - 8'h01;
            end
          end
        end
        ST_LOAD: begin
          // Leave only on a tick at zero: a part unit never cuts the wait
          if (unit_tick && wait_reg == 8'h00) begin
            state_reg <= ST_XFER;
          end else if (unit_tick) begin
            wait_reg <= wait_reg - 8'h01;
          end
        end
        ST_XFER: begin
          if (sector_end) begin
            state_reg <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (!last_on_track) begin
            sector_reg <= sector_reg + 8'h01;
            state_reg <= ST_XFER;
          end else if (ctrl_reg[`CTRL_MT] && !head_reg) begin
            head_reg <= 1'b1;
            sector_reg <= `FIRST_SECTOR;
            state_reg <= ST_XFER;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Step pulses and present cylinder tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_reg <= 1'b0;
      pcn_reg <= 8'h00;
    end else begin
      step_reg <= (state_reg == ST_SEEK) && steps_left_reg != 8'h00 && unit_tick && wait_reg <= 8'h01;
      if (step_reg) begin
        pcn_reg <= step_in_reg ? pcn_reg + 8'h01 : pcn_reg - 8'h01;
      end
    end
  end

  // Head stays loaded between commands until the unload interval runs out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_loaded_reg <= 1'b0;
      unload_cnt_reg <= 8'h00;
    end else if (soft_reset) begin
      head_loaded_reg <= 1'b0;
    end else if (state_reg == ST_LOAD) begin
      head_loaded_reg <= 1'b1;
      unload_cnt_reg <= head_unload_time_reg;
    end else if (state_reg != ST_IDLE) begin
      unload_cnt_reg <= head_unload_time_reg;
    end else if (head_loaded_reg && unit_tick) begin
      if (unload_cnt_reg == 8'h00) begin
        head_loaded_reg <= 1'b0;
      end else begin
        unload_cnt_reg <= unload_cnt_reg - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_idx_reg <= 15'h0000;
      crc_reg <= 16'hffff;
      crc_last_reg <= 16'h0000;
    end else if (state_reg != ST_XFER) begin
      byte_idx_reg <= 15'h0000;
      crc_reg <= 16'hffff;
    end else if (byte_done) begin
      byte_idx_reg <= byte_idx_reg + 15'h0001;
      // Every physical byte feeds the check code, host-visible or not
      crc_reg <= crc_step(crc_reg, (op_reg == OP_READ) ? disk_rd_byte
                                   : (host_part ? host_wr_byte : 8'h00));
      if (sector_end) begin
        crc_last_reg <= crc_step(crc_reg, (op_reg == OP_READ) ? disk_rd_byte
                                          : (host_part ? host_wr_byte : 8'h00));
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rd_byte <= 8'h00;
      host_rd_valid <= 1'b0;
      disk_wr_byte <= 8'h00;
      disk_wr_valid <= 1'b0;
    end else begin
      // Excess bytes are read off the disk but not handed up
      host_rd_valid <= byte_done && (op_reg == OP_READ) && host_part;
      if (byte_done && op_reg == OP_READ) begin
        host_rd_byte <= disk_rd_byte;
      end
      disk_wr_valid <= byte_done && (op_reg == OP_WRITE);
      if (byte_done && op_reg == OP_WRITE) begin
        disk_wr_byte <= host_part ? host_wr_byte : 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Drive outputs
  // ----------------------------------------
  always_comb begin
    drive_ctrl.drive_sel = ctrl_reg[`CTRL_DS_LSB +: 2];
    drive_ctrl.drive_enable = drive_decode(ctrl_reg[`CTRL_DS_LSB +: 2]);
    drive_ctrl.perpendicular = perp_drives_reg[ctrl_reg[`CTRL_DS_LSB +: 2]];
    drive_ctrl.head_sel = head_reg;
    drive_ctrl.head_loaded = head_loaded_reg;
    drive_ctrl.mfm_mode = ctrl_reg[`CTRL_MFM];
    drive_ctrl.step_in = step_in_reg;
    drive_ctrl.step = step_reg;
    // Alternate second gap only on a perpendicular drive
    drive_ctrl.gap_two_len = (gap_select_reg && drive_ctrl.perpendicular) ? gap_two_len_reg : 8'h16;
    drive_ctrl.gap_three_length = gap_three_length_reg;
  end
  assign busy = (state_reg != ST_IDLE);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        `OFS_CTRL: prdata_reg <= {20'h00000, ctrl_reg, 1'b0};
        `OFS_GEOM: prdata_reg <= {8'h00, last_sector_number_reg, special_sector_length_reg, 5'h00, size_code_reg};
        `OFS_GAP: prdata_reg <= {8'h00, perp_drives_reg, 3'h0, gap_select_reg, gap_two_len_reg,
                                 gap_three_length_reg};
        `OFS_TIME: prdata_reg <= {16'h0000, head_unload_time_reg, head_load_time_reg};
        `OFS_CONFIG: prdata_reg <= {16'h0000, precomp_start_track_reg, fifo_threshold_reg, 3'h0,
                                   fifo_enable_n_reg};
        `OFS_CYL: prdata_reg <= {24'h000000, cylinder_reg};
        `OFS_STATUS: prdata_reg <= {pcn_reg, sector_reg, 3'h0, head_loaded_reg, head_reg, state_reg, 8'h00};
        `OFS_CRC: prdata_reg <= {16'h0000, crc_last_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_reg;

endmodule : floppy_command_parameters

// File: testbench/fcp_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module fcp_props
  import fdc_param_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic disk_wr_valid,
  input wire logic host_rd_valid,
  input wire drive_ctrl_t drive_ctrl,
  input wire logic fifo_enable_n,
  input wire logic [3:0] fifo_threshold,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic acc;
  logic xfer;
  int idle_reg;

  assign acc = psel && penable && pwrite;
  assign xfer = disk_wr_valid || host_rd_valid;

  // Idle time with the head loaded; bound assumes one unload unit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_reg <= 0;
    end else begin
      idle_reg <= (!busy && drive_ctrl.head_loaded) ? idle_reg + 1 : 0;
    end
  end

  a_drive_onehot: assert property (drive_ctrl.drive_enable == 4'h1 << drive_ctrl.drive_sel)
    else $error("drive enable does not follow drive select");
  a_ctrl_fields: assert property (acc && paddr == 8'h00 && !pwdata[11] |=>
    drive_ctrl.drive_sel == $past(pwdata[5:4]) && drive_ctrl.mfm_mode == $past(pwdata[7]))
    else $error("control write not reflected on drive outputs");
  a_config_write: assert property (acc && paddr == 8'h10 |=>
    fifo_enable_n == $past(pwdata[0]) && fifo_threshold == $past(pwdata[7:4]))
    else $error("config write not reflected");
  a_gap_three: assert property (acc && paddr == 8'h08 |=> drive_ctrl.gap_three_length == $past(pwdata[7:0]))
    else $error("gap three length wrong");
  a_perp_drive: assert property (acc && paddr == 8'h08 |=>
    drive_ctrl.perpendicular == $past(pwdata[5'd20 + drive_ctrl.drive_sel]))
    else $error("perpendicular flag wrong for selected drive");
  a_gap_two_plain: assert property (!drive_ctrl.perpendicular |-> drive_ctrl.gap_two_len == 8'h16)
    else $error("gap two altered outside perpendicular mode");
  a_xfer_loaded: assert property (xfer |-> drive_ctrl.head_loaded && busy)
    else $error("data moved with head not loaded");
  a_load_wait: assert property ($rose(drive_ctrl.head_loaded) |-> (!xfer) [*4])
    else $error("data moved inside head load time");
  a_unload_bound: assert property (idle_reg <= 2 * TICK_CYCLES + 2)
    else $error("head stays loaded past unload time");
  a_step_busy: assert property (drive_ctrl.step |-> busy && !xfer)
    else $error("step outside a seek");

  c_step_in: cover property (drive_ctrl.step && drive_ctrl.step_in);
  c_head_one: cover property (host_rd_valid && drive_ctrl.head_sel);
  c_write: cover property (disk_wr_valid);
endmodule : fcp_props

bind floppy_command_parameters fcp_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .disk_wr_valid,
  .host_rd_valid, .drive_ctrl, .fifo_enable_n, .fifo_threshold, .busy
);

// File: testbench/disk_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Spinning disk model
// ----------------------------------------
module disk_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic slow,
  output logic disk_byte_tick,
  output logic [7:0] disk_rd_byte,
  output logic disk_rd_valid
);
  logic [2:0] div_reg;
  logic [7:0] data_reg;

  // The medium never stops, so byte slots come between commands too
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 3'h0;
      data_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 3'h1;
      data_reg <= disk_rd_valid ? data_reg + 8'h01 : data_reg;
    end
  end

  assign disk_byte_tick = slow ? (div_reg == 3'h7) : (div_reg[1:0] == 2'h3);
  assign disk_rd_valid = disk_byte_tick;
  // Off-slot the data lines show junk so a mistimed sample cannot match
  assign disk_rd_byte = disk_rd_valid ? data_reg : ~data_reg;
endmodule : disk_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fdc_param_pkg::*;
  localparam int TICK = 4;
  logic clk, arst_n, psel, penable, pwrite, slow, pready, pslverr, serr;
  logic disk_byte_tick, disk_rd_valid, disk_wr_valid, host_wr_valid, host_wr_ready, host_rd_valid, busy;
  logic fifo_enable_n;
  logic [3:0] fifo_threshold;
  logic [7:0] paddr, disk_rd_byte, disk_wr_byte, host_wr_byte, host_rd_byte, precomp_start_track;
  logic [31:0] pwdata, prdata, q;
  drive_ctrl_t drive_ctrl;
  int checked, mismatches;

  floppy_command_parameters #(.TICK_CYCLES(TICK)) i_dut (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .disk_byte_tick, .disk_rd_byte, .disk_rd_valid, .disk_wr_byte, .disk_wr_valid,
    .host_wr_byte, .host_wr_valid, .host_wr_ready, .host_rd_byte, .host_rd_valid,
    .drive_ctrl, .fifo_enable_n, .fifo_threshold, .precomp_start_track, .busy
  );
  disk_model i_disk (.clk, .arst_n, .slow, .disk_byte_tick, .disk_rd_byte, .disk_rd_valid);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [15:0] crc_sector(input logic [7:0] b0, input int keep);
    logic [15:0] c;
    logic [7:0] b;
    c = 16'hffff;
    for (int i = 0; i < 128; i++) begin
      b = (i < keep) ? 8'(b0 + i) : 8'h00;
      for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc_sector

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    apb(1'b0, 8'h04, 32'h0);
    chk("geom", 32'h0012ff00, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("config", 32'h1, q);
    chk("gap three", 32'h1b, 32'(drive_ctrl.gap_three_length));
    apb(1'b1, 8'h20, 32'h5);
    chk("unmapped err", 32'h1, 32'(serr));
  endtask : t_reset

  task automatic t_drives;
    apb(1'b1, 8'h08, 32'h00214c1e);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 8'h00, 32'h6 | (d << 4) | ((d & 1) << 7));
      @(negedge clk);
      chk("drive enable", 32'h1 << d, 32'(drive_ctrl.drive_enable));
      chk("mfm", d & 1, 32'(drive_ctrl.mfm_mode));
      chk("perpendicular", 32'(d == 1), 32'(drive_ctrl.perpendicular));
      chk("gap two", (d == 1) ? 32'h4c : 32'h16, 32'(drive_ctrl.gap_two_len));
    end
  endtask : t_drives

  task automatic t_seek(input int dir, input int n, input int pcn);
    int steps;
    steps = 0;
    apb(1'b1, 8'h14, n);
    apb(1'b1, 8'h00, 32'h5 | (dir << 3));
    repeat (2000) begin
      @(negedge clk);
      if (drive_ctrl.step === 1'b1) begin
        steps++;
        chk("step dir", dir, 32'(drive_ctrl.step_in));
      end
      if (busy !== 1'b1) break;
    end
    chk("steps", n, steps);
    apb(1'b0, 8'h18, 32'h0);
    chk("cylinder", pcn, q[31:24]);
    repeat (3 * TICK) @(posedge clk);
  endtask : t_seek

  task automatic t_read(input logic [31:0] geom, input logic [31:0] ctrl, input int nb, input int ns,
                        input int hd, input bit crc_on);
    int cnt, steps, lat;
    logic [7:0] first;
    cnt = 0;
    steps = 0;
    lat = 0;
    apb(1'b1, 8'h04, geom);
    apb(1'b1, 8'h00, ctrl | 32'h1);
    repeat (5000) begin
      @(negedge clk);
      lat++;
      if (drive_ctrl.step === 1'b1) steps++;
      if (host_rd_valid === 1'b1 && cnt == 0) first = host_rd_byte;
      if (host_rd_valid === 1'b1 && cnt == 0) chk("load wait", 1, 32'(lat > 2 * TICK));
      if (host_rd_valid === 1'b1 && crc_on) chk("rd byte", 8'(first + cnt), host_rd_byte);
      if (host_rd_valid === 1'b1) cnt++;
      if (busy !== 1'b1) break;
    end
    chk("rd count", nb, cnt);
    chk("seek steps", ns, steps);
    chk("head held", 1, 32'(drive_ctrl.head_loaded));
    repeat (3 * TICK) @(negedge clk);
    chk("head unloaded", 0, 32'(drive_ctrl.head_loaded));
    apb(1'b0, 8'h18, 32'h0);
    chk("head", hd, q[11]);
    chk("head sel", hd, drive_ctrl.head_sel);
    apb(1'b0, 8'h1c, 32'h0);
    if (crc_on) chk("crc", crc_sector(first, 128), q);
  endtask : t_read

  task automatic t_write;
    int cnt;
    logic tk;
    cnt = 0;
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'h00010400);
    host_wr_valid <= 1'b1;
    apb(1'b1, 8'h00, 32'h3);
    repeat (3000) begin
      @(negedge clk);
      tk = host_wr_valid && host_wr_ready;
      if (disk_wr_valid === 1'b1) chk("wr byte", cnt < 4 ? 8'(8'h40 + cnt) : 8'h00, disk_wr_byte);
      if (disk_wr_valid === 1'b1) cnt++;
      if (busy !== 1'b1) break;
      @(posedge clk);
      if (tk) host_wr_byte <= host_wr_byte + 8'h01;
    end
    host_wr_valid <= 1'b0;
    chk("wr count", 128, cnt);
    apb(1'b0, 8'h1c, 32'h0);
    chk("wr crc", crc_sector(8'h40, 4), q);
  endtask : t_write

  task automatic t_lock;
    apb(1'b1, 8'h10, 32'h3450);
    apb(1'b1, 8'h00, 32'h406);
    apb(1'b1, 8'h00, 32'hc06);
    apb(1'b0, 8'h10, 32'h0);
    chk("locked config", 32'h3450, q);
    chk("fifo enable", 0, fifo_enable_n);
    chk("precomp", 32'h34, precomp_start_track);
    apb(1'b1, 8'h00, 32'h006);
    apb(1'b1, 8'h00, 32'h806);
    apb(1'b0, 8'h10, 32'h0);
    chk("config restored", 32'h1, q);
  endtask : t_lock

  // ----------------------------------------
  // Clock, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    host_wr_valid = 1'b0;
    host_wr_byte = 8'h40;
    checked = 0;
    mismatches = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_drives();
    apb(1'b1, 8'h0c, 32'h0102);
    t_seek(1, 2, 2);
    t_seek(0, 1, 1);
    apb(1'b1, 8'h14, 32'h3);
    t_read(32'h00011000, 32'h000, 16, 0, 0, 1'b1);
    t_read(32'h00011000, 32'h200, 16, 2, 0, 1'b0);
    t_read(32'h00021000, 32'h040, 32, 0, 1, 1'b0);
    t_read(32'h00011000, 32'h100, 32, 0, 1, 1'b0);
    t_read(32'h00011001, 32'h000, 256, 0, 0, 1'b0);
    t_write();
    t_lock();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule : testbench
